// File: rtl/cdt_defines.svh
// register offsets, field positions and reset values of the card detect
// threshold compare block; definitions only
`ifndef CDT_DEFINES_SVH
`define CDT_DEFINES_SVH

// offsets are register indices; the byte address is four times the index
`define CDT_Q_LOW_OFFSET    8'h3F
`define CDT_Q_HIGH_OFFSET   8'h40
`define CDT_I_LOW_OFFSET    8'h41
`define CDT_I_RESULT_OFFSET 8'h42
`define CDT_Q_RESULT_OFFSET 8'h43
`define CDT_IRQ_STAT_OFFSET 8'h48
`define CDT_IRQ_MASK_OFFSET 8'h49

`define CDT_UPPER_HI_POS    7
`define CDT_UPPER_LO_POS    6
`define CDT_FIELD_MSB       5
`define CDT_SUPPRESS_POS    6
`define CDT_FLAG_POS        0

`define CDT_REG_RESET       8'h00
`define CDT_MASK_RESET      8'h00

`define CDT_RESP_OKAY       2'h0
`define CDT_RESP_SLVERR     2'h2

`endif

// File: rtl/cdt_pkg.sv
// types shared by the card detect threshold compare block
// assumes cdt_defines.svh holds all numbers
package cdt_pkg;

  // one detection result, I and Q channel
  typedef struct packed {
    logic [5:0] i_value;
    logic [5:0] q_value;
  } cdt_result_type;

  // read answer of the register slave
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } cdt_read_type;

endpackage : cdt_pkg

// File: rtl/cdt_threshold.sv
// card detect threshold compare with AXI4-Lite register slave
// assumes result_valid is a one-cycle pulse on sys_clk at the end of a
// detection cycle and detect_start a pulse when a detection procedure begins
//
// How it works
// - I upper border bits 3 and 2 live in bits 7 and 6 at 0x40.
// - I upper border bits 1 and 0 live in bits 7 and 6 at 0x41.
// - I upper border bits 5 and 4 live in bits 7 and 6 at 0x3F.
// - I result above assembled I upper border raises the detect interrupt.
// - Q upper border in bits 5..0 at 0x40; Q above it interrupts.
// - I lower border in bits 5..0 at 0x41; I below it interrupts.
// - Q lower border in bits 5..0 at 0x3F, read/write.
// - a raised detect interrupt sets the flag in the status register.
// - last I result reads at 0x42 bits 5..0, upper bits zero.
// - last Q result reads at 0x43 bits 5..0, bit 7 zero.
// - suppress bit 6 at 0x43 blocks interrupts until next detection.
`timescale 1ns/1ps
`include "cdt_defines.svh"

module cdt_threshold (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire cdt_pkg::cdt_result_type result_in,
  input  wire logic                  result_valid,
  input  wire logic                  detect_start,
  input  wire logic [9:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [9:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       irq
);

  // ******************************************************************
  // storage
  // ******************************************************************
  logic [7:0]             q_low_reg;   // 0x3F
  logic [7:0]             q_high_reg;  // 0x40
  logic [7:0]             i_low_reg;   // 0x41
  logic                   suppress;
  logic [7:0]             irq_mask;
  logic                   irq_flag;
  cdt_pkg::cdt_result_type last_result;

  // ******************************************************************
  // write channel: address and data latched independently
  // ******************************************************************
  logic       aw_held;
  logic       w_held;
  logic [9:0] aw_addr;
  logic [31:0] w_data;
  logic       w_lane0;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held | aw_take;
  wire have_w  = w_held | w_take;
  wire do_write = have_aw & have_w & ~s_axi_bvalid;
  wire [9:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire        wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];
  // one register per 32-bit word: odd indices would never decode otherwise
  wire [7:0]  wr_word = wr_addr[9:2];

  wire wr_q_low  = (wr_word == `CDT_Q_LOW_OFFSET);
  wire wr_q_high = (wr_word == `CDT_Q_HIGH_OFFSET);
  wire wr_i_low  = (wr_word == `CDT_I_LOW_OFFSET);
  wire wr_q_res  = (wr_word == `CDT_Q_RESULT_OFFSET);
  wire wr_mask   = (wr_word == `CDT_IRQ_MASK_OFFSET);
  wire wr_ro     = (wr_word == `CDT_I_RESULT_OFFSET) |
                   (wr_word == `CDT_IRQ_STAT_OFFSET);
  wire wr_hit    = wr_q_low | wr_q_high | wr_i_low | wr_q_res |
                   wr_mask | wr_ro;
  wire wr_en     = do_write & wr_lane;

  // ******************************************************************
  // detection compare
  // ******************************************************************
  // upper border is spread over three registers, two bits each
  wire [5:0] i_upper = {q_low_reg[`CDT_UPPER_HI_POS:`CDT_UPPER_LO_POS],
                        q_high_reg[`CDT_UPPER_HI_POS:`CDT_UPPER_LO_POS],
                        i_low_reg[`CDT_UPPER_HI_POS:`CDT_UPPER_LO_POS]};
  wire [5:0] q_upper = q_high_reg[`CDT_FIELD_MSB:0];
  wire [5:0] i_lower = i_low_reg[`CDT_FIELD_MSB:0];
  wire [5:0] q_lower = q_low_reg[`CDT_FIELD_MSB:0];

  wire i_above = result_in.i_value > i_upper;
  wire q_above = result_in.q_value > q_upper;
  wire i_below = result_in.i_value < i_lower;
  wire q_below = result_in.q_value < q_lower;
  wire outside = i_above | q_above | i_below | q_below;
  wire detect_event = result_valid & outside & ~suppress;

  // ******************************************************************
  // read channel
  // ******************************************************************
  wire [7:0] rd_word = s_axi_araddr[9:2];
  wire       rd_take = s_axi_arvalid & s_axi_arready;
  wire       rd_stat = (rd_word == `CDT_IRQ_STAT_OFFSET);
  wire [7:0] stat_byte = {7'h00, irq_flag};
  wire [7:0] rd_byte;
  wire       rd_hit;

  assign rd_byte =
    (rd_word == `CDT_Q_LOW_OFFSET)    ? q_low_reg :
    (rd_word == `CDT_Q_HIGH_OFFSET)   ? q_high_reg :
    (rd_word == `CDT_I_LOW_OFFSET)    ? i_low_reg :
    (rd_word == `CDT_I_RESULT_OFFSET) ? {2'h0, last_result.i_value} :
    (rd_word == `CDT_Q_RESULT_OFFSET) ? {1'b0, suppress,
                                         last_result.q_value} :
    rd_stat                           ? stat_byte :
    (rd_word == `CDT_IRQ_MASK_OFFSET) ? irq_mask : 8'h00;
  assign rd_hit = (rd_word == `CDT_Q_LOW_OFFSET) |
                  (rd_word == `CDT_Q_HIGH_OFFSET) |
                  (rd_word == `CDT_I_LOW_OFFSET) |
                  (rd_word == `CDT_I_RESULT_OFFSET) |
                  (rd_word == `CDT_Q_RESULT_OFFSET) | rd_stat |
                  (rd_word == `CDT_IRQ_MASK_OFFSET);

  wire stat_read_clear = rd_take & rd_stat;

  // ******************************************************************
  // next values
  // ******************************************************************
  // event wins over a read clear in the same cycle
  wire next_flag = detect_event | (irq_flag & ~stat_read_clear);
  // a new detection procedure releases the suppression
  wire next_suppress = (wr_en & wr_q_res) ? wr_data[`CDT_SUPPRESS_POS] :
                       detect_start ? 1'b0 : suppress;
  // mask taken at its next value, so a mask write shows on irq at once
  wire [7:0] next_mask = (wr_en & wr_mask) ? wr_data[7:0] : irq_mask;
  wire next_irq = |({7'h00, next_flag} & next_mask);

  // ******************************************************************
  // registers
  // ******************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q_low_reg  <= `CDT_REG_RESET;
      q_high_reg <= `CDT_REG_RESET;
      i_low_reg  <= `CDT_REG_RESET;
      irq_mask   <= `CDT_MASK_RESET;
    end else if (wr_en) begin
      if (wr_q_low) q_low_reg <= wr_data[7:0];
      if (wr_q_high) q_high_reg <= wr_data[7:0];
      if (wr_i_low) i_low_reg <= wr_data[7:0];
      if (wr_mask) irq_mask <= wr_data[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_result <= '0;
      suppress    <= 1'b0;
      irq_flag    <= 1'b0;
      irq         <= 1'b0;
    end else begin
      if (result_valid) last_result <= result_in;
      suppress <= next_suppress;
      irq_flag <= next_flag;
      irq      <= next_irq;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 10'h000;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else begin
      aw_held <= have_aw & ~do_write;
      w_held  <= have_w & ~do_write;
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CDT_RESP_OKAY;
    end else begin
      s_axi_awready <= ~(have_aw & ~do_write) & ~do_write &
                       ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready  <= ~(have_w & ~do_write) & ~do_write &
                       ~(s_axi_bvalid & ~s_axi_bready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CDT_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_hit ? `CDT_RESP_OKAY : `CDT_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cdt_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // a value inside the window, taken from the register bits, stays quiet
  upper_assembly_a: assert property (
    (result_valid && !irq_flag &&
     result_in.i_value <= {q_low_reg[7:6], q_high_reg[7:6],
                           i_low_reg[7:6]} &&
     result_in.i_value >= i_low_reg[5:0] &&
     result_in.q_value <= q_high_reg[5:0] &&
     result_in.q_value >= q_low_reg[5:0]) |=> !irq_flag)
    else $error("flag set for a value inside the window");

  i_above_flag_a: assert property (
    (result_valid && !suppress && result_in.i_value > i_upper)
    |=> irq_flag)
    else $error("i above border did not set flag");

  q_above_flag_a: assert property (
    (result_valid && !suppress && result_in.q_value > q_upper)
    |=> irq_flag)
    else $error("q above border did not set flag");

  i_below_flag_a: assert property (
    (result_valid && !suppress && result_in.i_value < i_lower)
    |=> irq_flag)
    else $error("i below border did not set flag");

  q_below_flag_a: assert property (
    (result_valid && !suppress && result_in.q_value < q_lower)
    |=> irq_flag)
    else $error("q below border did not set flag");

  flag_cause_a: assert property (
    $rose(irq_flag) |-> $past(result_valid) && !$past(suppress))
    else $error("flag set without detection event");

  suppress_hold_a: assert property (
    (suppress && !detect_start && !(wr_en && wr_q_res))
    |=> suppress && !$rose(irq_flag))
    else $error("suppression lost or flag set while suppressed");

  result_hold_a: assert property (
    result_valid |=> last_result == $past(result_in))
    else $error("last result not captured");

  q_low_write_a: assert property (
    (wr_en && wr_q_low) |=> q_low_reg == $past(wr_data[7:0]))
    else $error("q lower border write lost");

  irq_level_a: assert property (
    irq == (irq_flag && irq_mask[0]))
    else $error("interrupt output wrong");

  read_clear_a: assert property (
    (stat_read_clear && !detect_event) |=> !irq_flag)
    else $error("status read did not clear flag");

  suppress_release_a: assert property (
    (detect_start && !(wr_en && wr_q_res)) |=> !suppress)
    else $error("detection start did not release suppression");

  detect_seen_c: cover property (result_valid && outside ##1 irq_flag);
  suppressed_c: cover property (result_valid && outside && suppress);
  read_clear_c: cover property (irq_flag ##1 stat_read_clear ##1 !irq_flag);
  write_read_c: cover property (do_write ##[1:4] rd_take);

endmodule : cdt_threshold

// File: verif/cdt_threshold_tb.sv
// self-checking bench of the card detect threshold compare block
// assumes cdt_pkg and cdt_threshold are compiled before it
`timescale 1ns/1ps
`include "cdt_defines.svh"

module cdt_threshold_tb;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic                    sys_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    result_valid = 1'b0;
  logic                    detect_start = 1'b0;
  cdt_pkg::cdt_result_type result_in = '0;
  logic [9:0]  s_axi_awaddr = 10'h000;
  logic [9:0]  s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  // ready for answers at all times, so never dropped between transfers
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_data;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [5:0]  ci [6] = '{6'h27, 6'h28, 6'h20, 6'h0F, 6'h20, 6'h10};
  logic [5:0]  cq [6] = '{6'h30, 6'h20, 6'h31, 6'h20, 6'h07, 6'h08};
  logic        cf [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0]  regs [7] = '{`CDT_Q_LOW_OFFSET, `CDT_Q_HIGH_OFFSET,
    `CDT_I_LOW_OFFSET, `CDT_I_RESULT_OFFSET, `CDT_Q_RESULT_OFFSET,
    `CDT_IRQ_STAT_OFFSET, `CDT_IRQ_MASK_OFFSET};

  cdt_threshold u_dut (.sys_clk, .resetn, .result_in, .result_valid,
    .detect_start, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq);

  always #50 sys_clk = ~sys_clk;

  // about 130 cycles are needed; a hang ends the run here
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end

  // ****************************************
  // bus and check tasks
  // ****************************************
  // offsets are word indices; the byte address is four times the index
  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic done;
    done = 1'b0;
    s_axi_awaddr  <= byte_addr(idx);
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
      rsp  = s_axi_bresp;
    end
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    logic done;
    done = 1'b0;
    s_axi_araddr  <= byte_addr(idx);
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done    = s_axi_rvalid;
      rd_data = s_axi_rdata;
      rsp     = s_axi_rresp;
    end
  endtask : rd

  task automatic expect_reg(input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk("register", rd_data, {24'h0, e});
  endtask : expect_reg

  // one measurement; flag and irq settle one edge after the pulse
  task automatic det(input logic [5:0] i, q);
    result_in    <= '{i_value: i, q_value: q};
    result_valid <= 1'b1;
    @(posedge sys_clk);
    result_valid <= 1'b0;
    @(negedge sys_clk);
  endtask : det

  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int k = 0; k < 7; k++) expect_reg(regs[k], `CDT_REG_RESET);
    $display("test reset values done");
    wr(`CDT_Q_LOW_OFFSET, 8'hC5);
    chk("write resp", rsp, `CDT_RESP_OKAY);
    wr(`CDT_Q_HIGH_OFFSET, 8'h8A);
    wr(`CDT_I_LOW_OFFSET, 8'h7F);
    wr(`CDT_I_RESULT_OFFSET, 8'hFF);
    wr(`CDT_Q_RESULT_OFFSET, 8'hFF);
    expect_reg(`CDT_Q_LOW_OFFSET, 8'hC5);
    expect_reg(`CDT_Q_HIGH_OFFSET, 8'h8A);
    expect_reg(`CDT_I_LOW_OFFSET, 8'h7F);
    expect_reg(`CDT_I_RESULT_OFFSET, 8'h00);
    expect_reg(`CDT_Q_RESULT_OFFSET, 8'h40);
    wr(8'h30, 8'h55);
    chk("unmapped write", rsp, `CDT_RESP_SLVERR);
    rd(8'h30);
    chk("unmapped read", {rd_data[29:0], rsp}, {30'h0, `CDT_RESP_SLVERR});
    // byte lane 0 off: the write is answered but leaves the register alone
    s_axi_wstrb <= 4'hE;
    wr(`CDT_Q_HIGH_OFFSET, 8'h00);
    s_axi_wstrb <= 4'hF;
    chk("strobe resp", rsp, `CDT_RESP_OKAY);
    expect_reg(`CDT_Q_HIGH_OFFSET, 8'h8A);
    $display("test register access done");
    // upper I border 0x27 spread as 2,1,3 over the three registers
    wr(`CDT_Q_LOW_OFFSET, 8'h88);
    wr(`CDT_Q_HIGH_OFFSET, 8'h70);
    wr(`CDT_I_LOW_OFFSET, 8'hD0);
    wr(`CDT_Q_RESULT_OFFSET, 8'h00);
    wr(`CDT_IRQ_MASK_OFFSET, 8'h01);
    for (int k = 0; k < 6; k++) begin
      det(ci[k], cq[k]);
      chk("irq", irq, cf[k]);
      expect_reg(`CDT_I_RESULT_OFFSET, {2'b00, ci[k]});
      expect_reg(`CDT_Q_RESULT_OFFSET, {2'b00, cq[k]});
      expect_reg(`CDT_IRQ_STAT_OFFSET, {7'h00, cf[k]});
      expect_reg(`CDT_IRQ_STAT_OFFSET, 8'h00);
      @(negedge sys_clk);
      chk("irq cleared", irq, 1'b0);
    end
    $display("test window compare done");
    wr(`CDT_IRQ_MASK_OFFSET, 8'h00);
    det(6'h28, 6'h20);
    chk("masked irq", irq, 1'b0);
    wr(`CDT_IRQ_MASK_OFFSET, 8'h01);
    chk("unmasked irq", irq, 1'b1);
    expect_reg(`CDT_IRQ_STAT_OFFSET, 8'h01);
    $display("test mask done");
    wr(`CDT_Q_RESULT_OFFSET, 8'h40);
    det(6'h28, 6'h20);
    chk("suppressed irq", irq, 1'b0);
    expect_reg(`CDT_IRQ_STAT_OFFSET, 8'h00);
    expect_reg(`CDT_Q_RESULT_OFFSET, 8'h60);
    detect_start <= 1'b1;
    @(posedge sys_clk);
    detect_start <= 1'b0;
    expect_reg(`CDT_Q_RESULT_OFFSET, 8'h20);
    det(6'h28, 6'h20);
    chk("irq after restart", irq, 1'b1);
    $display("test suppress done");
    // reset again in mid-run: flag, irq and borders return to zero
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk("irq after reset", irq, 1'b0);
    expect_reg(`CDT_Q_LOW_OFFSET, `CDT_REG_RESET);
    expect_reg(`CDT_IRQ_STAT_OFFSET, 8'h00);
    $display("test reset again done");
    results();
  end
endmodule : cdt_threshold_tb
